// ==== hw/lcu_pkg.sv ====
package lcu_pkg;

  // Register map, byte addresses on the APB side
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_LINK_CTRL = 8'h00;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_PORT_STATE = 8'h0C;

  // Link control field positions
  localparam int EXT_SYNC_BIT = 7;
  localparam int CLK_PM_BIT = 8;
  localparam int AUTO_WD_BIT = 9;
  localparam int BW_IRQ_EN_BIT = 10;
  localparam int AUTO_BW_IRQ_EN_BIT = 11;
  localparam int RESV_LO_BIT = 12;
  localparam int RESV_HI_BIT = 15;

  // Interrupt status and mask layout
  localparam int IRQ_N = 2;
  localparam int STS_BW_BIT = 0;
  localparam int STS_AUTO_BIT = 1;

  // Port state register layout
  localparam int PS_CAP_BIT = 0;
  localparam int PS_UP_BIT = 1;
  localparam int PS_OS_BIT = 2;
  localparam int PS_CNT_LSB = 8;
  localparam int CNT_W = 8;

  // Reset values and the refusal count limit
  localparam logic EXT_SYNC_RESET = 1'h0;
  localparam logic BW_IRQ_EN_RESET = 1'h0;
  localparam logic AUTO_BW_IRQ_EN_RESET = 1'h0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h3;
  localparam logic [1:0] IRQ_STATUS_RESET = 2'h0;
  localparam logic [7:0] REFUSE_CNT_RESET = 8'h00;
  localparam logic [7:0] REFUSE_CNT_MAX = 8'hFF;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage

// ==== hw/lcu_bus_if.sv ====
`timescale 1ns/1ps
interface lcu_bus_if;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_stb;
  logic [31:0] rdata;
  logic hit;

  modport slave (
    output addr,
    output wdata,
    output wr_stb,
    input rdata,
    input hit
  );

  modport regs (
    input addr,
    input wdata,
    input wr_stb,
    output rdata,
    output hit
  );
endinterface

// ==== hw/lcu_apb_slave.sv ====
`timescale 1ns/1ps
module lcu_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  lcu_bus_if.slave bus
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lcu_apb_state_type;

  lcu_apb_state_type st;
  lcu_apb_state_type next_st;

  // One wait state: read data is captured while the master still holds the request
  always_comb begin
    next_st = st;
    next_st.pready = 1'b0;
    if (psel && penable && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !bus.hit;
      next_st.prdata = pwrite ? lcu_pkg::RDATA_RESET : bus.rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{pready: 1'b0, pslverr: 1'b0, prdata: lcu_pkg::RDATA_RESET};
    end else if (pce) begin
      st <= next_st;
    end
  end

  assign bus.addr = paddr;
  assign bus.wdata = pwdata;
  // Write lands on the edge where the master samples pready
  assign bus.wr_stb = psel && penable && pwrite && st.pready && bus.hit && pce;
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;

endmodule

// ==== hw/lcu_irq.sv ====
`timescale 1ns/1ps
module lcu_irq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic [1:0] set_evt,
  input wire logic [1:0] clr_w1c,
  input wire logic [1:0] gate,
  output logic [1:0] status,
  output logic irq
);

  typedef struct packed {
    logic [1:0] status;
    logic irq;
  } lcu_irq_state_type;

  lcu_irq_state_type st;
  lcu_irq_state_type next_st;
  logic [1:0] next_status;

  // Set beats a same-cycle write-one-to-clear so no event is lost
  for (genvar g = 0; g < lcu_pkg::IRQ_N; g++) begin : g_sts
    assign next_status[g] = set_evt[g] | (st.status[g] & ~clr_w1c[g]);
  end

  always_comb begin
    next_st = st;
    next_st.status = next_status;
    next_st.irq = |(next_status & gate);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{status: lcu_pkg::IRQ_STATUS_RESET, irq: 1'b0};
    end else if (pce) begin
      st <= next_st;
    end
  end

  assign status = st.status;
  assign irq = st.irq;

endmodule

// ==== hw/lcu_top.sv ====
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module lcu_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic upstream_port,
  input wire logic bw_notify_capable,
  input wire logic bw_mgmt_event,
  input wire logic auto_bw_event,
  input wire logic ltssm_exit_l0s,
  input wire logic ltssm_in_recovery,
  input wire logic width_fix_req,
  input wire logic width_reconfig_req,
  input wire logic width_other_req,
  output logic send_extra_os,
  output logic width_change_go,
  output logic width_change_refused,
  output logic irq
);

  typedef struct packed {
    logic ext_sync;
    logic bw_irq_en;
    logic auto_bw_irq_en;
    logic [1:0] irq_mask;
    logic send_os;
    logic width_go;
    logic width_refused;
    logic [7:0] refuse_cnt;
  } lcu_top_state_type;

  lcu_top_state_type st;
  lcu_top_state_type next_st;

  lcu_bus_if bus ();

  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic bw_allowed;
  logic width_ok;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [1:0] irq_gate;
  logic [1:0] irq_status;

  lcu_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus(bus.slave)
  );

  assign wr_ctrl = bus.wr_stb && (bus.addr == lcu_pkg::REG_LINK_CTRL);
  assign wr_status = bus.wr_stb && (bus.addr == lcu_pkg::REG_IRQ_STATUS);
  assign wr_mask = bus.wr_stb && (bus.addr == lcu_pkg::REG_IRQ_MASK);

  // Enables exist only on a downstream port with notification capability
  assign bw_allowed = bw_notify_capable && !upstream_port;

  // Only reliability fixes and reconfiguration requests may change width
  assign width_ok = width_fix_req || width_reconfig_req;

  assign irq_set[lcu_pkg::STS_BW_BIT] = bw_mgmt_event;
  assign irq_set[lcu_pkg::STS_AUTO_BIT] = auto_bw_event;
  assign irq_clr = wr_status ? bus.wdata[1:0] : 2'h0;
  assign irq_gate[lcu_pkg::STS_BW_BIT] = st.bw_irq_en && st.irq_mask[lcu_pkg::STS_BW_BIT];
  assign irq_gate[lcu_pkg::STS_AUTO_BIT] =
    st.auto_bw_irq_en && st.irq_mask[lcu_pkg::STS_AUTO_BIT];

  lcu_irq u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .set_evt(irq_set),
    .clr_w1c(irq_clr),
    .gate(irq_gate),
    .status(irq_status),
    .irq(irq)
  );

  always_comb begin
    next_st = st;
    if (wr_ctrl) begin
      next_st.ext_sync = bus.wdata[lcu_pkg::EXT_SYNC_BIT];
      next_st.bw_irq_en = bus.wdata[lcu_pkg::BW_IRQ_EN_BIT];
      next_st.auto_bw_irq_en = bus.wdata[lcu_pkg::AUTO_BW_IRQ_EN_BIT];
    end
    // Losing capability drops the enables, so a stale one cannot fire later
    if (!bw_allowed) begin
      next_st.bw_irq_en = 1'b0;
      next_st.auto_bw_irq_en = 1'b0;
    end
    if (wr_mask) begin
      next_st.irq_mask = bus.wdata[1:0];
    end
    next_st.send_os = st.ext_sync && (ltssm_exit_l0s || ltssm_in_recovery);
    // The width disable field does not appear here: it cannot block reconfiguration
    next_st.width_go = width_ok;
    next_st.width_refused = width_other_req && !width_ok;
    if (next_st.width_refused && (st.refuse_cnt != lcu_pkg::REFUSE_CNT_MAX)) begin
      next_st.refuse_cnt = st.refuse_cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{ext_sync: lcu_pkg::EXT_SYNC_RESET,
              bw_irq_en: lcu_pkg::BW_IRQ_EN_RESET,
              auto_bw_irq_en: lcu_pkg::AUTO_BW_IRQ_EN_RESET,
              irq_mask: lcu_pkg::IRQ_MASK_RESET,
              send_os: 1'b0,
              width_go: 1'b0,
              width_refused: 1'b0,
              refuse_cnt: lcu_pkg::REFUSE_CNT_RESET};
    end else if (pce) begin
      st <= next_st;
    end
  end

  // Read path; bits 6:0 of link control belong to another block and read zero here
  always_comb begin
    bus.rdata = lcu_pkg::RDATA_RESET;
    bus.hit = 1'b1;
    unique case (bus.addr)
      lcu_pkg::REG_LINK_CTRL: begin
        bus.rdata[lcu_pkg::EXT_SYNC_BIT] = st.ext_sync;
        bus.rdata[lcu_pkg::CLK_PM_BIT] = 1'b0;
        bus.rdata[lcu_pkg::AUTO_WD_BIT] = 1'b0;
        bus.rdata[lcu_pkg::BW_IRQ_EN_BIT] = st.bw_irq_en && bw_allowed;
        bus.rdata[lcu_pkg::AUTO_BW_IRQ_EN_BIT] = st.auto_bw_irq_en && bw_allowed;
        bus.rdata[lcu_pkg::RESV_HI_BIT:lcu_pkg::RESV_LO_BIT] = 4'h0;
      end
      lcu_pkg::REG_IRQ_STATUS: begin
        bus.rdata[1:0] = irq_status;
      end
      lcu_pkg::REG_IRQ_MASK: begin
        bus.rdata[1:0] = st.irq_mask;
      end
      lcu_pkg::REG_PORT_STATE: begin
        bus.rdata[lcu_pkg::PS_CAP_BIT] = bw_notify_capable;
        bus.rdata[lcu_pkg::PS_UP_BIT] = upstream_port;
        bus.rdata[lcu_pkg::PS_OS_BIT] = st.send_os;
        bus.rdata[lcu_pkg::PS_CNT_LSB +: lcu_pkg::CNT_W] = st.refuse_cnt;
      end
      default: begin
        bus.hit = 1'b0;
      end
    endcase
  end

  assign send_extra_os = st.send_os;
  assign width_change_go = st.width_go;
  assign width_change_refused = st.width_refused;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_extra_ordered_set_enable_os_sent: assert property (
    pce && st.ext_sync && (ltssm_exit_l0s || ltssm_in_recovery) |=> send_extra_os
  ) else $error("extra ordered sets not sent");

  a_extra_ordered_set_enable_os_quiet: assert property (
    pce && !(st.ext_sync && (ltssm_exit_l0s || ltssm_in_recovery)) |=> !send_extra_os
  ) else $error("extra ordered sets sent without cause");

  a_clkpm_reads_zero: assert property (
    (wr_ctrl && bus.wdata[lcu_pkg::CLK_PM_BIT]) ##1 (bus.addr == lcu_pkg::REG_LINK_CTRL)
      |-> !bus.rdata[lcu_pkg::CLK_PM_BIT]
  ) else $error("clock power management bit read as one");

  a_autowd_reads_zero: assert property (
    (wr_ctrl && bus.wdata[lcu_pkg::AUTO_WD_BIT]) ##1 (bus.addr == lcu_pkg::REG_LINK_CTRL)
      |-> !bus.rdata[lcu_pkg::AUTO_WD_BIT]
  ) else $error("autonomous width disable read as one");

  a_width_other_block: assert property (
    pce && width_other_req && !width_fix_req && !width_reconfig_req
      |=> !width_change_go && width_change_refused
  ) else $error("width changed for a disallowed reason");

  a_width_reconfig_go: assert property (
    pce && (width_reconfig_req || width_fix_req) |=> width_change_go && !width_change_refused
  ) else $error("width reconfiguration did not proceed");

  a_bw_irq_raise: assert property (
    pce && bw_mgmt_event && st.bw_irq_en && st.irq_mask[lcu_pkg::STS_BW_BIT] |=> irq
  ) else $error("bandwidth management interrupt missing");

  a_abw_irq_raise: assert property (
    pce && auto_bw_event && st.auto_bw_irq_en && st.irq_mask[lcu_pkg::STS_AUTO_BIT] |=> irq
  ) else $error("autonomous bandwidth interrupt missing");

  a_cap_gate_en: assert property (
    pce && !bw_notify_capable |=> !st.bw_irq_en && !st.auto_bw_irq_en
  ) else $error("enable held without notification capability");

  a_upstream_en_zero: assert property (
    pce && upstream_port |=> !st.bw_irq_en && !st.auto_bw_irq_en
  ) else $error("bandwidth enable set on upstream port");

  a_resv_reads_zero: assert property (
    (wr_ctrl && (bus.wdata[15:12] != 4'h0)) ##1 (bus.addr == lcu_pkg::REG_LINK_CTRL)
      |-> (bus.rdata[15:12] == 4'h0)
  ) else $error("reserved link control bits read nonzero");

  a_pready_pulse: assert property (
    pce && pready
      |=> !pready
  ) else $error("pready stood longer than one cycle");

  a_pready_answer: assert property (
    pce && psel && penable && !pready
      |=> pready
  ) else $error("access phase not answered after one wait state");

  a_unmapped_err: assert property (
    pce && psel && penable && !pready && !bus.hit
      |=> pslverr && (prdata == lcu_pkg::RDATA_RESET)
  ) else $error("unmapped access not refused");

  a_read_data: assert property (
    pce && psel && penable && !pready && !pwrite
      |=> prdata == $past(bus.rdata)
  ) else $error("read data not captured from the register");

  a_bw_sts_set: assert property (
    pce && bw_mgmt_event
      |=> irq_status[lcu_pkg::STS_BW_BIT]
  ) else $error("bandwidth management status not set");

  a_abw_sts_set: assert property (
    pce && auto_bw_event
      |=> irq_status[lcu_pkg::STS_AUTO_BIT]
  ) else $error("autonomous bandwidth status not set");

  a_sts_w1c: assert property (
    wr_status && bus.wdata[lcu_pkg::STS_BW_BIT] && !bw_mgmt_event
      |=> !irq_status[lcu_pkg::STS_BW_BIT]
  ) else $error("status bit not cleared by a written one");

  a_irq_gated_off: assert property (
    pce && (irq_gate == 2'h0)
      |=> !irq
  ) else $error("interrupt raised with every source gated");

  a_irq_upstream_off: assert property (
    (pce && upstream_port) ##1 pce
      |=> !irq
  ) else $error("interrupt raised on the upstream port");

  a_en_read_hidden: assert property (
    !bw_allowed && (bus.addr == lcu_pkg::REG_LINK_CTRL)
      |-> (bus.rdata[lcu_pkg::AUTO_BW_IRQ_EN_BIT:lcu_pkg::BW_IRQ_EN_BIT] == 2'h0)
  ) else $error("bandwidth enables read as set without permission");

  a_ctrl_write: assert property (
    wr_ctrl
      |=> st.ext_sync == $past(bus.wdata[lcu_pkg::EXT_SYNC_BIT])
  ) else $error("extra ordered set enable not written");

  a_en_write: assert property (
    wr_ctrl && bw_allowed
      |=> st.bw_irq_en == $past(bus.wdata[lcu_pkg::BW_IRQ_EN_BIT])
  ) else $error("bandwidth management enable not written");

  a_mask_write: assert property (
    wr_mask
      |=> st.irq_mask == $past(bus.wdata[1:0])
  ) else $error("interrupt mask not written");

  a_refuse_count: assert property (
    pce && width_other_req && !width_fix_req && !width_reconfig_req
      && (st.refuse_cnt != lcu_pkg::REFUSE_CNT_MAX)
      |=> st.refuse_cnt == $past(st.refuse_cnt) + 8'h01
  ) else $error("refused width change not counted");

  a_frozen_state: assert property (
    !pce
      |=> $stable(st) && $stable(irq) && $stable(pready)
  ) else $error("state moved while the clock enable was low");

endmodule

// ==== testbench/lcu_link_partner.sv ====
`timescale 1ns/1ps
module lcu_link_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [6:0] want,
  output logic [6:0] link
);
  // Between requests every line sits low, as an idle link shows no event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link <= '0;
    end else begin
      link <= want;
    end
  end
endmodule

// ==== testbench/link_control_upper_fields_test.sv ====
`timescale 1ns/1ps
module link_control_upper_fields_test;
  logic pclk = 0;
  logic presetn = 0;
  logic pce = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic upstream_port = 0;
  logic bw_notify_capable = 1;
  logic [6:0] want = 7'h00;
  logic [6:0] link;
  logic send_extra_os;
  logic width_change_go;
  logic width_change_refused;
  logic irq;
  logic [32:0] q[$];
  logic [32:0] e;
  logic [15:0] rnd = 16'h0033;
  int mismatches = 0;
  int samples_checked = 0;

  always #5 pclk = ~pclk;

  lcu_link_partner partner (.pclk(pclk), .presetn(presetn), .want(want), .link(link));

  lcu_top dut (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .upstream_port(upstream_port), .bw_notify_capable(bw_notify_capable),
    .bw_mgmt_event(link[5]), .auto_bw_event(link[6]), .ltssm_exit_l0s(link[0]),
    .ltssm_in_recovery(link[1]), .width_fix_req(link[2]), .width_reconfig_req(link[3]),
    .width_other_req(link[4]), .send_extra_os(send_extra_os),
    .width_change_go(width_change_go), .width_change_refused(width_change_refused), .irq(irq)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Master holds the request until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    q.push_back(exp);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 32'h0, {1'b0, x});
  endtask

  task automatic pulse(input int k, input logic [3:0] exp);
    @(posedge pclk);
    want <= 7'(1 << k);
    @(posedge pclk);
    want <= 7'h00;
    @(posedge pclk);
    @(negedge pclk);
    check({irq, width_change_refused, width_change_go, send_extra_os}, exp);
  endtask

  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      e = q.pop_front();
      if (pwrite) check({pslverr, 32'h0}, {e[32], 32'h0});
      else check({pslverr, prdata}, e);
    end
  end

  initial begin
    #300000;
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h3);
    rd(8'h0C, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr_next(rnd);
      wr(8'h00, {16'h0, rnd});
      rd(8'h00, {16'h0, rnd & 16'h0C80});
    end
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0C80);
    pulse(0, 4'b0001);
    pulse(1, 4'b0001);
    pulse(2, 4'b0010);
    pulse(3, 4'b0010);
    pulse(4, 4'b0100);
    rd(8'h0C, 32'h101);
    pulse(5, 4'b1000);
    rd(8'h04, 32'h1);
    wr(8'h04, 32'h1);
    pulse(6, 4'b1000);
    rd(8'h04, 32'h2);
    wr(8'h04, 32'h2);
    pulse(0, 4'b0001);
    wr(8'h08, 32'h0);
    pulse(5, 4'b0000);
    rd(8'h04, 32'h1);
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h3);
    apb(0, 8'h10, 32'h0, {1'b1, 32'h0});
    apb(1, 8'h10, 32'h5, {1'b1, 32'h0});
    wr(8'h00, 32'h0C00);
    pulse(1, 4'b0000);
    // Pass 0 drops the capability, pass 1 makes this the upstream port
    for (int j = 0; j < 2; j++) begin
      @(posedge pclk);
      bw_notify_capable <= j[0];
      upstream_port <= j[0];
      rd(8'h00, j ? 32'h80 : 32'h0);
      wr(8'h00, 32'h0C80);
      rd(8'h00, 32'h80);
      pulse(5, 4'b0000);
      wr(8'h04, 32'h1);
    end
    // Clock enable low must hold the side outputs, high must let them move again
    @(posedge pclk);
    pce <= 0;
    pulse(0, 4'b0000);
    @(posedge pclk);
    pce <= 1;
    pulse(0, 4'b0001);
    give_verdict();
  end
endmodule
